/* File: verilog/atr_adc_control.sv */
`timescale 1ns/1ns
// Function
// - Left-justified: result bits 3:0 appear in low byte bits 7:4.
// - Right-justified: result bits 7:0 fill the whole low byte.
// - Low result byte is read-only; writes leave the result unchanged.
// - Mode bit 7 enables hardware trigger; zero ignores trigger events.
// - Trigger select: int0, int1, pin change 7, then timers 0 to 4.
// - Converter clock is system clock, or half clock divided further when halving set.
// - Align bit 0 left-justifies, 1 right-justifies across high and low bytes.
// - High byte holds bits 11:4 left-justified, bits 11:8 right-justified.
// - A conversion lasts sixty converter clock cycles.
// - Mode register and high result share one address; read depends on powerdown.
// - Hardware events start conversions regardless of interrupt enable.
module atr_adc_control (
  // clock and reset
  input  wire logic                          core_clk_in,
  input  wire logic                          reset_in,
  // register bus
  input  wire logic [atr_pkg::ADDR_W-1:0]    reg_addr_in,
  input  wire logic [atr_pkg::DATA_W-1:0]    reg_wdata_in,
  input  wire logic                          reg_write_in,
  input  wire logic                          reg_read_in,
  output logic      [atr_pkg::DATA_W-1:0]    reg_rdata_out,
  // trigger events, one-cycle pulses from on-chip logic
  input  wire logic [atr_pkg::NUM_TRIG-1:0]  trigger_events_in,
  // analog converter side
  input  wire logic [atr_pkg::RESULT_W-1:0]  sample_value_in,
  output logic                               converter_clock_out,
  output logic                               converter_busy_out,
  output logic                               converter_powerdown_out,
  // interrupt
  output logic                               irq_out
);
  import atr_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0]     mode_two;
    logic                  powerdown;
    logic                  busy;
    logic [CONV_CNT_W-1:0] cycle_count;
    logic [RESULT_W-1:0]   result;
    logic [STAT_W-1:0]     status;
    logic [STAT_W-1:0]     mask;
    logic [DATA_W-1:0]     rdata;
  } atr_state_t;

  atr_state_t state_reg;
  atr_state_t state_next;

  logic                       tick;
  logic                       hw_trigger_enable;
  logic [TSEL_W-1:0]          trigger_source_select;
  logic                       clock_halving_select;
  logic                       align_right;
  logic [DIV_W-1:0]           converter_clock_divider;
  logic                       selected_event;
  logic                       sw_start;
  logic                       start_request;
  logic                       conv_last;
  logic [DATA_W-1:0]          result_high_byte;
  logic [DATA_W-1:0]          result_low_byte;
  logic [DATA_W-1:0]          read_value;
  logic [STAT_W-1:0]          status_set;

  //////////////////////////////////////////////////////////////////////////////
  // field views

  assign hw_trigger_enable       = state_reg.mode_two[MODE_HW_TRIGGER_BIT];
  assign trigger_source_select   = state_reg.mode_two[MODE_TSEL_LSB +: TSEL_W];
  assign clock_halving_select    = state_reg.mode_two[MODE_HALVING_BIT];
  assign align_right             = state_reg.mode_two[MODE_ALIGN_BIT];
  assign converter_clock_divider = state_reg.mode_two[MODE_DIV_LSB +: DIV_W];

  //////////////////////////////////////////////////////////////////////////////
  // converter clock

  atr_clock_divider u_divider (
    .core_clk_in                (core_clk_in),
    .reset_in                   (reset_in),
    .enable_in                  (!state_reg.powerdown),
    .clock_halving_select_in    (clock_halving_select),
    .converter_clock_divider_in (converter_clock_divider),
    .converter_clock_out        (tick)
  );

  //////////////////////////////////////////////////////////////////////////////
  // result formatting

  always_comb begin
    if (align_right) begin
      result_high_byte = {{(DATA_W-LOW_NIBBLE_W){1'b0}},
                          state_reg.result[RESULT_W-1 -: LOW_NIBBLE_W]};
      result_low_byte  = state_reg.result[DATA_W-1:0];
    end else begin
      result_high_byte = state_reg.result[RESULT_W-1 -: DATA_W];
      result_low_byte  = {state_reg.result[LOW_NIBBLE_W-1:0],
                          {(DATA_W-LOW_NIBBLE_W){1'b0}}};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // start logic

  // trigger source decode; events are indexed by their select code
  // events are raw pulses, independent of any interrupt enable
  assign selected_event = trigger_events_in[trigger_source_select];
  assign sw_start       = reg_write_in && (reg_addr_in == ADDR_CONTROL)
                          && reg_wdata_in[CTRL_START_BIT];
  // hardware start behaves as a software start
  assign start_request  = !state_reg.powerdown &&
                          (sw_start || (hw_trigger_enable && selected_event));
  assign conv_last      = state_reg.busy && tick &&
                          (state_reg.cycle_count == CONV_CNT_W'(CONV_CYCLES - 1));

  //////////////////////////////////////////////////////////////////////////////
  // read mux

  always_comb begin
    read_value = '0;
    if (reg_addr_in == ADDR_MODE_TWO) begin
      read_value = state_reg.powerdown ? state_reg.mode_two : result_high_byte;
    end else if (reg_addr_in == ADDR_RESULT_LOW) begin
      read_value = result_low_byte;
    end else if (reg_addr_in == ADDR_CONTROL) begin
      read_value[CTRL_POWERDOWN_BIT] = state_reg.powerdown;
      read_value[CTRL_START_BIT]     = state_reg.busy;
    end else if (reg_addr_in == ADDR_STATUS) begin
      read_value[STAT_W-1:0] = state_reg.status;
    end else if (reg_addr_in == ADDR_MASK) begin
      read_value[STAT_W-1:0] = state_reg.mask;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    state_next       = state_reg;
    status_set       = '0;
    state_next.rdata = reg_read_in ? read_value : '0;

    if (reg_write_in) begin
      // writes to the shared address always land in the mode register, never the result
      if (reg_addr_in == ADDR_MODE_TWO) begin
        state_next.mode_two = reg_wdata_in;
      end else if (reg_addr_in == ADDR_CONTROL) begin
        state_next.powerdown = reg_wdata_in[CTRL_POWERDOWN_BIT];
      end else if (reg_addr_in == ADDR_MASK) begin
        state_next.mask = reg_wdata_in[STAT_W-1:0];
      end
      // no write path to the low result byte
    end

    if (state_reg.busy) begin
      if (start_request) begin
        status_set[STAT_OVERRUN_BIT] = 1'b1;
      end
      if (conv_last) begin
        state_next.busy        = 1'b0;
        state_next.cycle_count = '0;
        state_next.result      = sample_value_in;
        status_set[STAT_DONE_BIT] = 1'b1;
      end else if (tick) begin
        state_next.cycle_count = state_reg.cycle_count + 1'b1;
      end
    end else if (start_request) begin
      // start; later triggers only set the overrun flag until done
      state_next.busy        = 1'b1;
      state_next.cycle_count = '0;
    end

    // powering down aborts a conversion without touching the result
    if (state_next.powerdown) begin
      state_next.busy        = 1'b0;
      state_next.cycle_count = '0;
    end

    // read clears status; a new event in the same cycle still wins
    if (reg_read_in && reg_addr_in == ADDR_STATUS) begin
      state_next.status = status_set;
    end else begin
      state_next.status = state_reg.status | status_set;
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_reg.mode_two    <= MODE_TWO_RESET;
      state_reg.powerdown   <= CTRL_POWERDOWN_RESET;
      state_reg.busy        <= 1'b0;
      state_reg.cycle_count <= '0;
      state_reg.result      <= '0;
      state_reg.status      <= STAT_RESET;
      state_reg.mask        <= STAT_RESET;
      state_reg.rdata       <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign reg_rdata_out           = state_reg.rdata;
  assign converter_clock_out     = tick;
  assign converter_busy_out      = state_reg.busy;
  assign converter_powerdown_out = state_reg.powerdown;
  assign irq_out                 = |(state_reg.status & state_reg.mask);

  //////////////////////////////////////////////////////////////////////////////
  // assertions

  sequence seq_read_low;
    reg_read_in && reg_addr_in == ADDR_RESULT_LOW;
  endsequence

  sequence seq_read_shared;
    reg_read_in && reg_addr_in == ADDR_MODE_TWO;
  endsequence

  sequence seq_hw_start;
    hw_trigger_enable && !state_reg.powerdown && !state_reg.busy
      && selected_event && !reg_write_in;
  endsequence

  sequence seq_finish;
    state_reg.busy && tick && state_reg.cycle_count == CONV_CNT_W'(CONV_CYCLES - 1)
      && !state_next.powerdown;
  endsequence

  AST_LEFT_LOW: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (seq_read_low and !align_right and $stable(state_reg.result)) |=>
      reg_rdata_out == {$past(state_reg.result[3:0]), 4'h0})
    else $error("left-justified low byte wrong");

  AST_RIGHT_LOW: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (seq_read_low and align_right) |=> reg_rdata_out == $past(state_reg.result[7:0]))
    else $error("right-justified low byte wrong");

  AST_LOW_READ_ONLY: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (reg_write_in && reg_addr_in == ADDR_RESULT_LOW && !conv_last) |=>
      $stable(state_reg.result))
    else $error("write changed the result");

  AST_TRIGGER_OFF: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (!hw_trigger_enable && !state_reg.busy && !reg_write_in) |=> !state_reg.busy)
    else $error("conversion started without a start");

  AST_TRIGGER_ON: assert property (@(posedge core_clk_in) disable iff (reset_in)
    seq_hw_start |=> state_reg.busy && state_reg.cycle_count == '0)
    else $error("selected trigger did not start");

  AST_FULL_RATE: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (!clock_halving_select && !state_reg.powerdown) |-> tick)
    else $error("converter clock not at full rate");

  AST_HALF_RATE: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (clock_halving_select && tick && !reg_write_in) |=> !tick)
    else $error("halved converter clock ticked twice");

  AST_CONV_END: assert property (@(posedge core_clk_in) disable iff (reset_in)
    seq_finish |=> !state_reg.busy && state_reg.status[STAT_DONE_BIT]
      && state_reg.result == $past(sample_value_in))
    else $error("conversion did not end after sixty ticks");

  AST_COUNT_BOUND: assert property (@(posedge core_clk_in) disable iff (reset_in)
    state_reg.cycle_count < CONV_CNT_W'(CONV_CYCLES))
    else $error("conversion count overran");

  AST_SHARED_MODE: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (seq_read_shared and state_reg.powerdown) |=> reg_rdata_out == $past(state_reg.mode_two))
    else $error("shared address did not return mode register");

  AST_SHARED_HIGH: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (seq_read_shared and !state_reg.powerdown and !align_right) |=>
      reg_rdata_out == $past(state_reg.result[11:4]))
    else $error("shared address did not return high result");

  AST_BUSY_HOLD: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (state_reg.busy && !conv_last && !state_next.powerdown) |=>
      state_reg.busy && $stable(state_reg.result))
    else $error("trigger disturbed a running conversion");

  AST_HIGH_RIGHT: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (seq_read_shared and !state_reg.powerdown and align_right) |=>
      reg_rdata_out == {4'h0, $past(state_reg.result[11:8])})
    else $error("shared address did not return right-justified high result");

  AST_MODE_WRITE: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (reg_write_in && reg_addr_in == ADDR_MODE_TWO) |=>
      state_reg.mode_two == $past(reg_wdata_in))
    else $error("mode register write lost");

  AST_OVERRUN: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (state_reg.busy && start_request) |=> state_reg.status[STAT_OVERRUN_BIT])
    else $error("start during conversion not flagged");

  AST_IRQ_LEVEL: assert property (@(posedge core_clk_in) disable iff (reset_in)
    irq_out == |(state_reg.status & state_reg.mask))
    else $error("interrupt output mismatch");

endmodule // atr_adc_control

/* File: verilog/atr_pkg.sv */
package atr_pkg;

  // register bus
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  localparam logic [ADDR_W-1:0] ADDR_MODE_TWO   = 8'h9B;
  localparam logic [ADDR_W-1:0] ADDR_RESULT_LOW = 8'h9C;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL    = 8'hA0;
  localparam logic [ADDR_W-1:0] ADDR_STATUS     = 8'hA1;
  localparam logic [ADDR_W-1:0] ADDR_MASK       = 8'hA2;

  // converter_mode_two fields
  localparam int unsigned MODE_HW_TRIGGER_BIT = 7;
  localparam int unsigned MODE_TSEL_LSB       = 4;
  localparam int unsigned TSEL_W              = 3;
  localparam int unsigned MODE_HALVING_BIT    = 3;
  localparam int unsigned MODE_ALIGN_BIT      = 2;
  localparam int unsigned MODE_DIV_LSB        = 0;
  localparam int unsigned DIV_W               = 2;
  localparam logic [DATA_W-1:0] MODE_TWO_RESET = 8'h01;

  // control register fields
  localparam int unsigned CTRL_POWERDOWN_BIT = 0;
  localparam int unsigned CTRL_START_BIT     = 1;
  localparam logic CTRL_POWERDOWN_RESET      = 1'b1;

  // status and mask fields
  localparam int unsigned STAT_DONE_BIT    = 0;
  localparam int unsigned STAT_OVERRUN_BIT = 1;
  localparam int unsigned STAT_W           = 2;
  localparam logic [STAT_W-1:0] STAT_RESET = 2'h0;

  // conversion
  localparam int unsigned RESULT_W     = 12;
  localparam int unsigned NUM_TRIG     = 8;
  localparam int unsigned CONV_CYCLES  = 60;
  localparam int unsigned CONV_CNT_W   = 6;
  localparam int unsigned PRESCALE_W   = 4;
  localparam int unsigned LOW_NIBBLE_W = 4;

  // trigger source encodings
  localparam logic [TSEL_W-1:0] TSEL_EXT_INT0   = 3'h0;
  localparam logic [TSEL_W-1:0] TSEL_EXT_INT1   = 3'h1;
  localparam logic [TSEL_W-1:0] TSEL_PIN_CHANGE = 3'h2;
  localparam logic [TSEL_W-1:0] TSEL_TIMER0     = 3'h3;
  localparam logic [TSEL_W-1:0] TSEL_TIMER4     = 3'h7;

endpackage : atr_pkg

/* File: verilog/atr_clock_divider.sv */
`timescale 1ns/1ns
module atr_clock_divider (
  // clock and reset
  input  wire logic                       core_clk_in,
  input  wire logic                       reset_in,
  // configuration
  input  wire logic                       enable_in,
  input  wire logic                       clock_halving_select_in,
  input  wire logic [atr_pkg::DIV_W-1:0]  converter_clock_divider_in,
  // converter clock tick
  output logic                            converter_clock_out
);
  import atr_pkg::*;

  typedef struct packed {
    logic [PRESCALE_W-1:0] count;
  } atr_div_state_t;

  atr_div_state_t state_reg;
  atr_div_state_t state_next;
  logic [PRESCALE_W-1:0] last_count;

  // halved clock further divided by two to the power of the divider field
  always_comb begin
    last_count = clock_halving_select_in ?
                 PRESCALE_W'((2 << converter_clock_divider_in) - 1) : '0;
    state_next = state_reg;
    if (!enable_in || state_reg.count >= last_count) begin
      state_next.count = '0;
    end else begin
      state_next.count = state_reg.count + 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // source select
  // full rate ticks at once, even while a count left from halving drains
  assign converter_clock_out = enable_in && (!clock_halving_select_in || state_reg.count == '0);

endmodule // atr_clock_divider

/* File: bench/atr_cpu_model.sv */
`timescale 1ns/1ns
module atr_cpu_model (
  // clock
  input  wire logic                       core_clk_in,
  // register bus
  input  wire logic [atr_pkg::DATA_W-1:0] reg_rdata_in,
  output logic      [atr_pkg::ADDR_W-1:0] reg_addr_out,
  output logic      [atr_pkg::DATA_W-1:0] reg_wdata_out,
  output logic                            reg_write_out,
  output logic                            reg_read_out
);
  import atr_pkg::*;
  initial begin
    reg_addr_out = '0;
    reg_wdata_out = '0;
    reg_write_out = 1'b0;
    reg_read_out = 1'b0;
  end
  ////////////////////////////////////////
  // released write data shows the inverse, so a stale value never passes
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge core_clk_in);
    reg_addr_out <= a;
    reg_wdata_out <= v;
    reg_write_out <= 1'b1;
    @(posedge core_clk_in);
    reg_write_out <= 1'b0;
    reg_wdata_out <= ~v;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge core_clk_in);
    reg_addr_out <= a;
    reg_read_out <= 1'b1;
    @(posedge core_clk_in);
    reg_read_out <= 1'b0;
    #1;
    v = reg_rdata_in;
  endtask
endmodule // atr_cpu_model

/* File: bench/adc_trigger_and_result_format_bench.sv */
`timescale 1ns/1ns
module adc_trigger_and_result_format_bench;
  import atr_pkg::*;
  `define CHK(a, e, m) begin checks++; if ((a) !== (e)) begin err_count++; \
    $display("wrong value at %0t: %s", $time, m); end end
  logic                core_clk_in = 1'b0;
  logic                reset_in    = 1'b1;
  logic [ADDR_W-1:0]   addr;
  logic [DATA_W-1:0]   wdata;
  logic [DATA_W-1:0]   rdata;
  logic [DATA_W-1:0]   d;
  logic                wr_s;
  logic                rd_s;
  logic [NUM_TRIG-1:0] trig = '0;
  logic [RESULT_W-1:0] smp  = '0;
  logic                tick;
  logic                busy;
  logic                pwd;
  logic                irq;
  logic [15:0]         exp;
  int                  err_count = 0;
  int                  checks    = 0;
  int                  tcnt, bcnt, cyc, last, gap, i;
  always #2 core_clk_in = ~core_clk_in;
  atr_adc_control uut (.core_clk_in(core_clk_in), .reset_in(reset_in),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_write_in(wr_s),
    .reg_read_in(rd_s), .reg_rdata_out(rdata), .trigger_events_in(trig),
    .sample_value_in(smp), .converter_clock_out(tick), .converter_busy_out(busy),
    .converter_powerdown_out(pwd), .irq_out(irq));
  atr_cpu_model cpu (.core_clk_in(core_clk_in), .reg_rdata_in(rdata),
    .reg_addr_out(addr), .reg_wdata_out(wdata), .reg_write_out(wr_s),
    .reg_read_out(rd_s));
  ////////////////////////////////////////
  // converter ticks and busy cycles seen during a conversion
  always @(posedge core_clk_in) begin
    cyc++;
    if (busy === 1'b1 && tick === 1'b1) begin
      if (tcnt > 0) `CHK(cyc - last, gap, "tick spacing")
      last = cyc;
      tcnt++;
    end
    if (busy === 1'b1) bcnt++;
  end
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // new mode and fresh sample, counters cleared while idle
  task automatic arm(input logic [7:0] mode, input int g);
    cpu.wr(ADDR_MODE_TWO, mode);
    smp <= RESULT_W'($urandom_range(4095));
    gap = g;
    tcnt = 0;
    bcnt = 0;
  endtask
  task automatic pulse(input int k);
    @(posedge core_clk_in);
    trig <= NUM_TRIG'(1) << k;
    @(posedge core_clk_in);
    trig <= '0;
  endtask
  task automatic finish_conv(input bit right);
    int n;
    n = 0;
    #1;
    while (busy === 1'b1 && n < 1200) begin
      @(posedge core_clk_in);
      #1;
      n++;
    end
    if (n >= 1200) begin
      err_count++;
      end_of_test();
    end
    `CHK(tcnt, 60, "tick count")
    if (gap == 1) `CHK(bcnt, 60, "busy cycles")
    exp = right ? {8'(smp >> 8), 8'(smp)} : {8'(smp >> 4), 8'(smp << 4)};
    cpu.rd(ADDR_MODE_TWO, d);
    `CHK(d, exp[15:8], "high byte")
    cpu.rd(ADDR_RESULT_LOW, d);
    `CHK(d, exp[7:0], "low byte")
  endtask
  ////////////////////////////////////////
  initial begin
    void'($urandom(32'h3EBE5A00));
    repeat (2) @(posedge core_clk_in);
    reset_in <= 1'b0;
    cpu.rd(ADDR_MODE_TWO, d);
    `CHK(d, MODE_TWO_RESET, "mode reset")
    cpu.rd(8'h10, d);
    `CHK(d, 8'h00, "unmapped read")
    `CHK(pwd, 1'b1, "powerdown reset")
    cpu.wr(ADDR_CONTROL, 8'h00);
    // mask stays clear: hardware starts do not need the interrupt
    for (i = 0; i < NUM_TRIG; i++) begin
      arm(8'(i << MODE_TSEL_LSB), 1);
      pulse(i);
      #1;
      `CHK(busy, 1'b0, "trigger disabled")
      arm(8'h80 | 8'(i << MODE_TSEL_LSB), 1);
      pulse((i + 1) % NUM_TRIG);
      #1;
      `CHK(busy, 1'b0, "wrong source")
      pulse(i);
      pulse(i);
      finish_conv(1'b0);
      `CHK(irq, 1'b0, "masked irq")
      cpu.rd(ADDR_STATUS, d);
      `CHK(d, 8'h03, "done and overrun")
    end
    // software sets halving for a fast clock; leaving it off stays legal
    for (i = 0; i < 4; i++) begin
      arm(8'h08 | 8'(i), 2 << i);
      cpu.wr(ADDR_CONTROL, 8'h02);
      finish_conv(1'b0);
    end
    arm(8'h04, 1);
    cpu.wr(ADDR_CONTROL, 8'h02);
    finish_conv(1'b1);
    cpu.wr(ADDR_RESULT_LOW, ~exp[7:0]);
    cpu.rd(ADDR_RESULT_LOW, d);
    `CHK(d, exp[7:0], "read-only low")
    cpu.wr(ADDR_MASK, 8'h01);
    #1;
    `CHK(irq, 1'b1, "irq raised")
    cpu.rd(ADDR_STATUS, d);
    `CHK(d, 8'h01, "status done")
    #1;
    `CHK(irq, 1'b0, "irq cleared")
    cpu.wr(ADDR_CONTROL, 8'h01);
    cpu.wr(ADDR_MODE_TWO, 8'h5A);
    cpu.rd(ADDR_MODE_TWO, d);
    `CHK(d, 8'h5A, "mode readback")
    end_of_test();
  end
endmodule // adc_trigger_and_result_format_bench
